// ### core/lcd_screen_blink_frame_timing.sv
// LCD screen select, auto-scroll, blink, frame inversion and frame-rate timing
//
// Decided for this implementation: strobed register access.
`include "lcd_timing_map.svh"

// Function
// - Auto-scroll bit set steps through all four screens in turn.
// - Scroll step period comes from the two-bit blink rate field.
// - With blink enable and auto-scroll both set, scroll and do not blink.
// - Inversion bit set inverts every second frame; clear inverts none.
// - Screen select field picks which of screens 0 to 3 is shown.
// - Update-done bit sets once memory is taken up and a frame starts.
// - While hold bit is set, data registers are not used for display.
// - After hold clears, data registers are used again from next frame.
// - Blink source 00 forces display off, 01 forces it on.
// - Blink source 10 blinks at 2 Hz; 11 uses the blink rate field.
// - Blink rate field counts only for source 11: 1, 1/2, 1/3, 1/4 Hz.
// - At 2048 Hz and 2x, LCD rate is 2048/(4(n+1)); code 0 gives 16 Hz.
// - Frame divider is bits 3:0 of the clock register, reset 0000.
// - Clock select one gives 128 Hz LCD clock, zero gives 2048 Hz.
// - Blink enable turns blinking on, shaped by source and rate fields.
module lcd_screen_blink_frame_timing #(
	parameter int FAST_DIV = `LCD_SYS_CLK_HZ / `LCD_CLK_FAST_HZ,
	parameter int SLOW_DIV = `LCD_SYS_CLK_HZ / `LCD_CLK_SLOW_HZ,
	parameter int QUARTER_FAST = `LCD_CLK_FAST_HZ / `LCD_QUARTERS_PER_SEC,
	parameter int QUARTER_SLOW = `LCD_CLK_SLOW_HZ / `LCD_QUARTERS_PER_SEC
) (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire lcd_timing_pkg::reg_req_type reg_req_i,
	output logic [7:0] rd_data_o,
	output logic irq_o,
	output lcd_timing_pkg::lcd_drive_type drive_o
);

	// Software-visible registers
	logic [7:0] main_cfg;
	logic [7:0] clk_cfg;
	logic [7:0] scr_cfg;
	logic update_done;
	logic [`LCD_IRQ_W-1:0] irq_stat;
	logic [`LCD_IRQ_W-1:0] irq_mask;
	logic [`LCD_IRQ_W-1:0] irq_event;

	// Timing state
	logic [19:0] sys_cnt;
	logic lcd_clk_tick;
	logic [7:0] rate_cnt;
	logic rate_tick;
	logic [1:0] phase;
	logic frame_edge;
	logic [9:0] quarter_cnt;
	logic quarter_tick;
	logic [3:0] blink_cnt;
	logic blink_phase;
	logic [4:0] scroll_cnt;
	logic [1:0] scroll_idx;
	logic resume_pend;

	// Decoded fields
	logic lcd_en;
	logic blink_en;
	logic slow_clk;
	logic [1:0] mux;
	logic [1:0] blk_mod;
	logic [1:0] blk_freq;
	logic [3:0] fd;
	logic autoscroll;
	logic hold;
	logic wr_hit_scr;
	logic [1:0] last_phase;
	logic [7:0] rate_period;
	logic [9:0] quarter_len;
	logic [3:0] blink_len;
	logic [4:0] scroll_len;
	logic next_on;
	logic [1:0] next_screen;

	assign lcd_en = main_cfg[`LCD_MAIN_EN];
	assign blink_en = main_cfg[`LCD_MAIN_BLINK];
	assign slow_clk = main_cfg[`LCD_MAIN_LCD_CLOCK_SOURCE_SELECT];
	assign mux = main_cfg[`LCD_MAIN_MUX];
	assign blk_mod = clk_cfg[`LCD_CLK_BLINK_SOURCE_MODE];
	assign blk_freq = clk_cfg[`LCD_CLK_BLINK_RATE_SELECT];
	assign fd = clk_cfg[`LCD_CLK_FD];
	assign autoscroll = scr_cfg[`LCD_SCR_SCROLL];
	assign hold = scr_cfg[`LCD_SCR_HOLD];
	assign wr_hit_scr = reg_req_i.wr && (reg_req_i.addr == `LCD_OFS_SCR);

	// LCD rate period in LCD clock ticks for the divider code
	function automatic logic [7:0] lcd_period(input logic [3:0] code, input logic slow,
		input logic [1:0] mx);
		logic [7:0] base;
		logic wide;
		// Add after widening, so that code 15 gives 64 and does not wrap to zero
		base = {2'h0, code, 2'h0} + 8'h4;
		wide = (mx == `LCD_MUX_3X) || (mx == `LCD_MUX_4X);
		lcd_period = base;
		if (!slow)
		begin
			if (code == `LCD_FD_ZERO)
				lcd_period = `LCD_FAST_CODE0_PER;
			else
				lcd_period = base;
			if (wide)
				lcd_period = lcd_period >> 1;
		end
		else if (code == `LCD_FD_MAX)
			lcd_period = `LCD_SLOW_MAX_PER;
		else if (code == `LCD_FD_ZERO)
			lcd_period = `LCD_SLOW_CODE0_PER;
		else if (wide)
			lcd_period = `LCD_SLOW_PER_3X4X;
		else if ((base >> 1) > `LCD_SLOW_CAP_2X)
			lcd_period = `LCD_SLOW_CAP_2X;
		else
			lcd_period = base >> 1;
	endfunction : lcd_period

	// Combinational selections from the configuration
	always_comb
	begin
		rate_period = lcd_period(fd, slow_clk, mux);
		quarter_len = slow_clk ? 10'(QUARTER_SLOW) : 10'(QUARTER_FAST);
		case (mux)
			`LCD_MUX_3X: last_phase = 2'h2;
			`LCD_MUX_4X: last_phase = 2'h3;
			default: last_phase = 2'h1;
		endcase
		if (blk_mod == `LCD_BLK_FIXED)
			blink_len = `LCD_FIXED_QUARTERS;
		else
			blink_len = {({1'b0, blk_freq} + 3'h1), 1'b0};
		scroll_len = {({1'b0, blk_freq} + 3'h1), 2'h0};
		if (!lcd_en)
			next_on = 1'b0;
		else if (!blink_en || autoscroll)
			next_on = 1'b1;
		else
		begin
			case (blk_mod)
				`LCD_BLK_OFF: next_on = 1'b0;
				`LCD_BLK_ON: next_on = 1'b1;
				default: next_on = blink_phase;
			endcase
		end
		next_screen = autoscroll ? scroll_idx : scr_cfg[`LCD_SCR_SEL];
	end

	// LCD clock from the system clock; a one-cycle enable, not a clock
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sys_cnt <= 20'h0;
			lcd_clk_tick <= 1'b0;
		end
		else if (!lcd_en)
		begin
			sys_cnt <= 20'h0;
			lcd_clk_tick <= 1'b0;
		end
		else if (sys_cnt >= (slow_clk ? 20'(SLOW_DIV - 1) : 20'(FAST_DIV - 1)))
		begin
			sys_cnt <= 20'h0;
			lcd_clk_tick <= 1'b1;
		end
		else
		begin
			sys_cnt <= sys_cnt + 20'h1;
			lcd_clk_tick <= 1'b0;
		end
	end

	// LCD rate divider and COM phase; a frame ends when the phase wraps
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rate_cnt <= 8'h0;
			rate_tick <= 1'b0;
			phase <= 2'h0;
			frame_edge <= 1'b0;
		end
		else
		begin
			rate_tick <= 1'b0;
			frame_edge <= 1'b0;
			if (lcd_clk_tick)
			begin
				if (rate_cnt + 8'h1 >= rate_period)
				begin
					rate_cnt <= 8'h0;
					rate_tick <= 1'b1;
				end
				else
					rate_cnt <= rate_cnt + 8'h1;
			end
			if (rate_tick)
			begin
				if (phase >= last_phase)
				begin
					phase <= 2'h0;
					frame_edge <= 1'b1;
				end
				else
					phase <= phase + 2'h1;
			end
		end
	end

	// Quarter-second base from the LCD clock for blink and scroll
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			quarter_cnt <= 10'h0;
			quarter_tick <= 1'b0;
		end
		else
		begin
			quarter_tick <= 1'b0;
			if (lcd_clk_tick)
			begin
				if (quarter_cnt + 10'h1 >= quarter_len)
				begin
					quarter_cnt <= 10'h0;
					quarter_tick <= 1'b1;
				end
				else
					quarter_cnt <= quarter_cnt + 10'h1;
			end
		end
	end

	// Blink phase toggles every half period; shown only at a frame edge
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			blink_cnt <= 4'h0;
			blink_phase <= 1'b1;
		end
		else if (quarter_tick)
		begin
			if (blink_cnt + 4'h1 >= blink_len)
			begin
				blink_cnt <= 4'h0;
				blink_phase <= !blink_phase;
			end
			else
				blink_cnt <= blink_cnt + 4'h1;
		end
	end

	// Scroll index walks 0..3 and wraps, one step per scroll period
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			scroll_cnt <= 5'h0;
			scroll_idx <= 2'h0;
		end
		else if (!autoscroll)
		begin
			scroll_cnt <= 5'h0;
			scroll_idx <= scr_cfg[`LCD_SCR_SEL];
		end
		else if (quarter_tick)
		begin
			// Five bits: the slowest step is sixteen quarters
			if (scroll_cnt + 5'h1 >= scroll_len)
			begin
				scroll_cnt <= 5'h0;
				scroll_idx <= scroll_idx + 2'h1;
			end
			else
				scroll_cnt <= scroll_cnt + 5'h1;
		end
	end

	// Drive outputs; screen and blanking change only at frame edges; inversion rises at a frame edge but drops as soon as its bit clears
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			drive_o <= '0;
		else
		begin
			drive_o.com_phase <= phase;
			drive_o.frame_tick <= frame_edge;
			drive_o.data_latch <= frame_edge && !hold;
			if (frame_edge)
			begin
				drive_o.screen <= next_screen;
				drive_o.on <= next_on;
				drive_o.invert <= scr_cfg[`LCD_SCR_INV] && !drive_o.invert;
			end
			else if (!scr_cfg[`LCD_SCR_INV])
				drive_o.invert <= 1'b0;
		end
	end

	// A release of hold is remembered until the next frame takes the data up
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			resume_pend <= 1'b1;
		else if (frame_edge && !hold)
			resume_pend <= 1'b0;
		else if (wr_hit_scr && hold && !reg_req_i.wdata[`LCD_SCR_HOLD])
			resume_pend <= 1'b1;
	end

	// Update-done flag; a set in the same cycle as a clear wins
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			update_done <= 1'b0;
		else if (frame_edge && !hold && resume_pend)
			update_done <= 1'b1;
		else if (wr_hit_scr && reg_req_i.wdata[`LCD_SCR_DONE])
			update_done <= 1'b0;
	end

	// Configuration writes; reserved bits are stored but steer nothing
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			main_cfg <= `LCD_RST_MAIN;
			clk_cfg <= `LCD_RST_CLK;
			scr_cfg <= `LCD_RST_SCR;
			irq_mask <= '0;
		end
		else if (reg_req_i.wr)
		begin
			case (reg_req_i.addr)
				`LCD_OFS_MAIN: main_cfg <= reg_req_i.wdata;
				`LCD_OFS_CLK: clk_cfg <= reg_req_i.wdata;
				`LCD_OFS_SCR: scr_cfg <= reg_req_i.wdata & ~(8'h1 << `LCD_SCR_DONE);
				`LCD_OFS_IRQ_MASK: irq_mask <= reg_req_i.wdata[`LCD_IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	assign irq_event[`LCD_IRQ_FRAME] = frame_edge;
	assign irq_event[`LCD_IRQ_DONE] = frame_edge && !hold && resume_pend;
	assign irq_event[`LCD_IRQ_BLINK] = frame_edge && (next_on != drive_o.on);
	assign irq_event[`LCD_IRQ_SCROLL] = frame_edge && (next_screen != drive_o.screen);

	// Sticky status bits, write one to clear, set wins over clear
	generate
		for (genvar i = 0; i < `LCD_IRQ_W; i++)
		begin : g_stat
			always_ff @(posedge mclk_i or negedge arst_n_i)
			begin
				if (!arst_n_i)
					irq_stat[i] <= 1'b0;
				else if (irq_event[i])
					irq_stat[i] <= 1'b1;
				else if (reg_req_i.wr && (reg_req_i.addr == `LCD_OFS_IRQ_STAT)
					&& reg_req_i.wdata[i])
					irq_stat[i] <= 1'b0;
			end
		end
	endgenerate

	// Interrupt level from the registered status and mask
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(irq_stat & irq_mask);
	end

	// Read data stands for one cycle after the strobe; unmapped reads zero
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			rd_data_o <= 8'h0;
		else if (!reg_req_i.rd)
			rd_data_o <= 8'h0;
		else
		begin
			case (reg_req_i.addr)
				`LCD_OFS_MAIN: rd_data_o <= main_cfg;
				`LCD_OFS_CLK: rd_data_o <= clk_cfg;
				`LCD_OFS_SCR: rd_data_o <= {scr_cfg[7:2], update_done, scr_cfg[0]};
				`LCD_OFS_IRQ_STAT: rd_data_o <= {4'h0, irq_stat};
				`LCD_OFS_IRQ_MASK: rd_data_o <= {4'h0, irq_mask};
				default: rd_data_o <= 8'h0;
			endcase
		end
	end

endmodule : lcd_screen_blink_frame_timing

// ### shared/lcd_timing_map.svh
// Register offsets, field positions, reset values and timing figures of the LCD timing block
`ifndef LCD_TIMING_MAP_SVH
`define LCD_TIMING_MAP_SVH
`define LCD_SYS_CLK_HZ 100000000
`define LCD_CLK_FAST_HZ 2048
`define LCD_CLK_SLOW_HZ 128
`define LCD_QUARTERS_PER_SEC 4
`define LCD_OFS_MAIN 8'h95
`define LCD_OFS_CLK 8'h96
`define LCD_OFS_SCR 8'hb1
`define LCD_OFS_IRQ_STAT 8'hc0
`define LCD_OFS_IRQ_MASK 8'hc1
`define LCD_RST_MAIN 8'h01
`define LCD_RST_CLK 8'h00
`define LCD_RST_SCR 8'h00
`define LCD_MAIN_EN 7
`define LCD_MAIN_BLINK 5
`define LCD_MAIN_LCD_CLOCK_SOURCE_SELECT 3
`define LCD_MAIN_MUX 1:0
`define LCD_CLK_BLINK_SOURCE_MODE 7:6
`define LCD_CLK_BLINK_RATE_SELECT 5:4
`define LCD_CLK_FD 3:0
`define LCD_SCR_SCROLL 7
`define LCD_SCR_INV 6
`define LCD_SCR_RSVD 5:4
`define LCD_SCR_SEL 3:2
`define LCD_SCR_DONE 1
`define LCD_SCR_HOLD 0
`define LCD_MUX_3X 2'h2
`define LCD_MUX_4X 2'h3
`define LCD_BLK_OFF 2'h0
`define LCD_BLK_ON 2'h1
`define LCD_BLK_FIXED 2'h2
`define LCD_BLK_RATE 2'h3
`define LCD_FD_ZERO 4'h0
`define LCD_FD_MAX 4'hf
`define LCD_FAST_CODE0_PER 8'h80
`define LCD_SLOW_CODE0_PER 8'h02
`define LCD_SLOW_MAX_PER 8'h01
`define LCD_SLOW_CAP_2X 8'h08
`define LCD_SLOW_PER_3X4X 8'h04
`define LCD_FIXED_QUARTERS 4'h1
`define LCD_IRQ_FRAME 0
`define LCD_IRQ_DONE 1
`define LCD_IRQ_BLINK 2
`define LCD_IRQ_SCROLL 3
`define LCD_IRQ_W 4
`endif

// ### shared/lcd_timing_pkg.sv
// Types shared by the LCD screen, blink and frame timing block
package lcd_timing_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_type;
	typedef struct packed {
		logic [1:0] screen;
		logic on;
		logic invert;
		logic [1:0] com_phase;
		logic frame_tick;
		logic data_latch;
	} lcd_drive_type;
endpackage : lcd_timing_pkg

// ### tb/lcd_glass_model.sv
// LCD glass model that counts frames and pattern take-ups on the drive bus
module lcd_glass_model
(
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire lcd_timing_pkg::lcd_drive_type drive_i,
	output int frames_o,
	output int latches_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Glass takes a new pattern only at a frame start
	always_ff @(posedge mclk_i or negedge arst_n_i)
		if (!arst_n_i)
		begin
			frames_o <= 0;
			latches_o <= 0;
		end
		else
		begin
			frames_o <= frames_o + int'(drive_i.frame_tick);
			latches_o <= latches_o + int'(drive_i.data_latch);
		end
endmodule : lcd_glass_model

// ### tb/lcd_timing_properties.sv
// Port checker for the LCD screen, blink and frame timing block
module lcd_timing_properties
(
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire lcd_timing_pkg::reg_req_type reg_req_i,
	input wire logic [7:0] rd_data_o,
	input wire logic irq_o,
	input wire lcd_timing_pkg::lcd_drive_type drive_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!arst_n_i);
	chk_read_idle: assert property (!$past(reg_req_i.rd) |-> rd_data_o == 8'h00)
		else $error("read data outside its slot");
	chk_tick_space: assert property (drive_o.frame_tick |=> !drive_o.frame_tick [*8])
		else $error("frame ticks too close");
	chk_screen_frame: assert property ($changed(drive_o.screen) |-> drive_o.frame_tick)
		else $error("screen changed off a frame edge");
	chk_on_frame: assert property ($changed(drive_o.on) |-> drive_o.frame_tick)
		else $error("blanking changed off a frame edge");
	chk_inv_alternate: assert property (drive_o.frame_tick && drive_o.invert
		|-> !$past(drive_o.invert))
		else $error("two inverted frames in a row");
	chk_inv_rise: assert property ($rose(drive_o.invert) |-> drive_o.frame_tick)
		else $error("inversion began off a frame edge");
	chk_latch_frame: assert property (drive_o.data_latch |-> drive_o.frame_tick)
		else $error("take-up outside frame start");
	chk_phase_start: assert property (drive_o.frame_tick |-> drive_o.com_phase == 2'h0)
		else $error("frame did not start on phase zero");
	// Main traffic seen at least once
	cov_latch: cover property (drive_o.data_latch);
	cov_invert: cover property ($rose(drive_o.invert));
	cov_irq: cover property ($rose(irq_o));
endmodule : lcd_timing_properties

bind lcd_screen_blink_frame_timing lcd_timing_properties lcd_timing_properties_i (
	.mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_req_i(reg_req_i),
	.rd_data_o(rd_data_o), .irq_o(irq_o), .drive_o(drive_o));

// ### tb/tb_lcd_screen_blink_frame_timing.sv
// Testbench for the LCD screen, blink and frame timing block
module tb_lcd_screen_blink_frame_timing;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_i;
	logic arst_n_i;
	lcd_timing_pkg::reg_req_type req;
	lcd_timing_pkg::lcd_drive_type drive_o;
	logic [7:0] rd_data_o;
	logic irq_o;
	int frames;
	int latches;
	int n_fail = 0;
	int n_compared = 0;
	// Short LCD clock and quarter second keep the run small: one frame is 64 cycles at code 1
	lcd_screen_blink_frame_timing #(.FAST_DIV(4), .SLOW_DIV(8), .QUARTER_FAST(64),
		.QUARTER_SLOW(2)) lcd_screen_blink_frame_timing_i (.mclk_i(mclk_i),
		.arst_n_i(arst_n_i), .reg_req_i(req),
		.rd_data_o(rd_data_o), .irq_o(irq_o), .drive_o(drive_o));
	lcd_glass_model lcd_glass_model_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
		.drive_i(drive_o), .frames_o(frames), .latches_o(latches));
	initial
	begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	task automatic wrap_up;
		if (n_fail == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %0t got %0h exp %0h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge mclk_i);
		req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk_i);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge mclk_i);
		req.rd <= 1'b0;
		#1;
		chk(rd_data_o, exp);
	endtask : rd
	// Bounded wait for n frame starts; running out ends the run
	task automatic wait_frames(input int n);
		int k;
		k = 0;
		for (int t = 0; t < 40000 && k < n; t++)
		begin
			@(posedge mclk_i);
			#1;
			k += int'(drive_o.frame_tick);
		end
		if (k < n)
		begin
			n_fail++;
			wrap_up();
		end
	endtask : wait_frames
	task automatic per(output int c);
		c = 0;
		wait_frames(1);
		do
		begin
			@(posedge mclk_i);
			#1;
			c++;
		end
		while (drive_o.frame_tick !== 1'b1 && c < 5000);
	endtask : per
	function automatic logic [1:0] cur(input bit scr);
		return scr ? drive_o.screen : {1'b0, drive_o.on};
	endfunction : cur
	// Frames between the second and third change; the first may be cut short by a mode switch
	task automatic span(input bit scr, output int f);
		logic [1:0] v;
		int e;
		e = 0;
		f = 0;
		v = cur(scr);
		for (int t = 0; t < 60000 && e < 3; t++)
		begin
			@(posedge mclk_i);
			#1;
			if (e == 2)
				f += int'(drive_o.frame_tick);
			if (cur(scr) !== v)
			begin
				e++;
				v = cur(scr);
			end
		end
		if (e < 3)
			f = -1;
	endtask : span
	task automatic t_rates;
		logic [7:0] m[5] = '{8'h81, 8'h81, 8'h81, 8'h82, 8'h89};
		logic [7:0] k[5] = '{8'h01, 8'h0f, 8'h00, 8'h01, 8'h0f};
		int x[5] = '{64, 512, 1024, 48, 16};
		int c;
		for (int i = 0; i < 5; i++)
		begin
			wr(8'h95, m[i]);
			wr(8'h96, k[i]);
			wait_frames(2);
			per(c);
			chk(c, x[i]);
		end
	endtask : t_rates
	task automatic t_screens;
		for (int s = 0; s < 4; s++)
		begin
			wr(8'hb1, 8'(s << 2));
			wait_frames(2);
			chk(drive_o.screen, s);
		end
	endtask : t_screens
	task automatic t_invert;
		logic p;
		wr(8'hb1, 8'h40);
		wait_frames(2);
		p = drive_o.invert;
		wait_frames(1);
		chk(drive_o.invert, !p);
		wr(8'hb1, 8'h00);
		wait_frames(2);
		chk(drive_o.invert, 1'b0);
	endtask : t_invert
	task automatic t_blink;
		int f;
		wr(8'h95, 8'ha1);
		wr(8'h96, 8'h01);
		wait_frames(2);
		chk(drive_o.on, 1'b0);
		wr(8'h96, 8'h41);
		wait_frames(2);
		chk(drive_o.on, 1'b1);
		wr(8'h96, 8'h81);
		span(0, f);
		chk(f, 4);
		for (int r = 0; r < 4; r++)
		begin
			wr(8'h96, {2'h3, 2'(r), 4'h1});
			span(0, f);
			chk(f, 8 * (r + 1));
		end
	endtask : t_blink
	task automatic t_scroll;
		int f;
		logic [1:0] s;
		wr(8'h96, 8'hc1);
		wr(8'hb1, 8'h80);
		span(1, f);
		chk(f, 16);
		s = drive_o.screen;
		wait_frames(16);
		chk(drive_o.screen, 2'(s + 2'h1));
		chk(drive_o.on, 1'b1);
		wr(8'h96, 8'hf1);
		span(1, f);
		chk(f, 64);
		wr(8'hb1, 8'h00);
	endtask : t_scroll
	task automatic t_hold;
		int l;
		int fr;
		wr(8'hb1, 8'h03);
		// Count from a frame start, a step after the glass counters have settled
		wait_frames(1);
		l = latches;
		fr = frames;
		wait_frames(2);
		chk(latches - l, 0);
		chk(frames - fr, 2);
		rd(8'hb1, 8'h01);
		wr(8'hb1, 8'h00);
		wait_frames(2);
		rd(8'hb1, 8'h02);
		chk(latches > l, 1);
	endtask : t_hold
	task automatic t_irq;
		chk(irq_o, 1'b0);
		wr(8'hc1, 8'h01);
		rd(8'hc1, 8'h01);
		wait_frames(1);
		@(posedge mclk_i);
		#1;
		chk(irq_o, 1'b1);
		rd(8'hc0, 8'h0f);
		wr(8'h95, 8'h01);
		// A frame already under way when the block stops must land before the clear
		repeat (4) @(posedge mclk_i);
		wr(8'hc0, 8'h0f);
		@(posedge mclk_i);
		#1;
		chk(irq_o, 1'b0);
		rd(8'hc0, 8'h00);
		rd(8'h42, 8'h00);
	endtask : t_irq
	// Main sequence
	initial
	begin
		req = '0;
		arst_n_i = 1'b0;
		repeat (2) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		rd(8'h95, 8'h01);
		rd(8'h96, 8'h00);
		rd(8'hb1, 8'h00);
		t_rates();
		t_screens();
		t_invert();
		t_blink();
		t_scroll();
		t_hold();
		t_irq();
		wrap_up();
	end
endmodule : tb_lcd_screen_blink_frame_timing
